// ==== pkg/c8x_defines.vh ====
// Opcode, flag position, cycle and vector constants for the execute slice.
`ifndef C8X_DEFINES_VH
`define C8X_DEFINES_VH
// ==========================================================
// Opcode pages and opcodes
`define C8X_PAGE2 8'h10
`define C8X_PAGE3 8'h11
`define C8X_OP_PSH_SYS 8'h34
`define C8X_OP_PUL_SYS 8'h35
`define C8X_OP_PSH_USR 8'h36
`define C8X_OP_PUL_USR 8'h37
`define C8X_OP_TRAP 8'h3f
`define C8X_OP_MUL 8'h3d
`define C8X_OP_SEXT 8'h1d
`define C8X_OP_XFER 8'h1f
`define C8X_OP_EXCH 8'h1e
`define C8X_OP_TST_A 8'h4d
`define C8X_OP_TST_B 8'h5d
`define C8X_OP_TST_DIR 8'h0d
`define C8X_OP_TST_IDX 8'h6d
`define C8X_OP_TST_EXT 8'h7d
`define C8X_OP_FLAGS_OR_IMMEDIATE 8'h1a
`define C8X_OP_RTI 8'h3b
`define C8X_OP_SHR_A 8'h44
`define C8X_OP_SHR_B 8'h54
`define C8X_OP_SBC_A 8'h82
`define C8X_OP_SBC_B 8'hc2
`define C8X_OP_LBRN 8'h21
// ==========================================================
// Flag register bit positions
`define C8X_CC_E 7
`define C8X_CC_F 6
`define C8X_CC_H 5
`define C8X_CC_I 4
`define C8X_CC_N 3
`define C8X_CC_Z 2
`define C8X_CC_V 1
`define C8X_CC_C 0
`define C8X_CC_RESET 8'h50
// ==========================================================
// Cycle counts
`define C8X_CYC_STACK 5'h05
`define C8X_CYC_TRAP1 5'h13
`define C8X_CYC_TRAP23 5'h14
`define C8X_CYC_MUL 5'h0b
`define C8X_CYC_SEXT 5'h02
`define C8X_CYC_XFER 5'h06
`define C8X_CYC_EXCH 5'h08
`define C8X_CYC_INH 5'h02
`define C8X_CYC_TST_DIR 5'h06
`define C8X_CYC_TST_IDX 5'h06
`define C8X_CYC_TST_EXT 5'h07
`define C8X_CYC_FLAGS_OR_IMMEDIATE 5'h03
`define C8X_CYC_RTI_S 5'h06
`define C8X_CYC_RTI_L 5'h0f
`define C8X_CYC_LBR 5'h05
`define C8X_CYC_ILL 5'h02
// ==========================================================
// Trap vectors (high byte address) and stack masks: full set, PC only, flags only
`define C8X_VEC_TRAP1 16'hfffa
`define C8X_VEC_TRAP2 16'hfff4
`define C8X_VEC_TRAP3 16'hfff2
`define C8X_MASK_ALL 8'hff
`define C8X_MASK_PC 8'h80
`define C8X_MASK_CC 8'h01
// ==========================================================
// Register codes for transfer and exchange
`define C8X_R_D 4'h0
`define C8X_R_X 4'h1
`define C8X_R_Y 4'h2
`define C8X_R_U 4'h3
`define C8X_R_S 4'h4
`define C8X_R_PC 4'h5
`define C8X_R_A 4'h8
`define C8X_R_B 4'h9
`define C8X_R_CC 4'ha
`define C8X_R_DP 4'hb
`endif

// ==== hdl/c8x_idx_cost.v ====
// Extra cycles and bytes demanded by an indexed-mode postbyte.
`timescale 1ns/1ps
module c8x_idx_cost (
	// Postbyte in
	input wire [7:0] post,
	// Cost out
	output reg [3:0] extra_cyc,
	output reg [1:0] extra_byt
);
	// ==========================================================
	// Decode
	always @* begin
		extra_cyc = 4'h0;
		extra_byt = 2'h0;
		if (!post[7]) begin
			extra_cyc = 4'h1;
		end else begin
			case (post[3:0])
			4'h0, 4'h2: extra_cyc = 4'h2;
			4'h1, 4'h3: extra_cyc = 4'h3;
			4'h4: extra_cyc = 4'h0;
			4'h5, 4'h6: extra_cyc = 4'h1;
			4'h8: begin
				extra_cyc = 4'h1;
				extra_byt = 2'h1;
			end
			4'h9: begin
				extra_cyc = 4'h4;
				extra_byt = 2'h2;
			end
			4'hb: extra_cyc = 4'h4;
			4'hc: begin
				extra_cyc = 4'h1;
				extra_byt = 2'h1;
			end
			4'hd: begin
				extra_cyc = 4'h5;
				extra_byt = 2'h2;
			end
			4'hf: begin
				extra_cyc = 4'h2;
				extra_byt = 2'h2;
			end
			default: extra_cyc = 4'h0;
			endcase
			// Indirection costs three more cycles.
			if (post[4])
				extra_cyc = extra_cyc + 4'h3;
		end
	end
endmodule // c8x_idx_cost

// ==== hdl/c8x_exec.v ====
// Execute slice: stack, trap, multiply, transfer, test and flag ops.
// What this block does
// [RULE1] Push opcodes store selected registers to stack.
// [RULE2] Pull opcodes restore selected registers from stack.
// [RULE3] Stack ops take five plus one per byte.
// [RULE4] First trap masks both; others leave masks.
// [RULE5] Multiply unsigned, carry from bit seven, eleven.
// [RULE6] Sign extend fills high, sets N Z, two.
// [RULE7] Transfer and exchange need equal register widths.
// [RULE8] Eight-bit set: accumulators, flags, direct page.
// [RULE9] Sixteen-bit set: index, stacks, D, PC.
// [RULE10] Test sets N Z, clears V, unchanged.
// [RULE11] Long branch: five not taken, six taken.
// [RULE12] Indexed forms add postbyte extra cycles.
// [RULE13] Subtract with borrow leaves half-carry undefined.
// [RULE14] Return and flag OR set flags directly.
// [RULE15] Prefix bytes select second and third page.
// [RULE16] Traps stack entire register set first.
// [RULE17] Logical shift right: zero in, carry out.
`timescale 1ns/1ps
`include "c8x_defines.vh"
module c8x_exec (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// Instruction issue
	input wire ins_valid,
	output wire ins_ready,
	input wire [7:0] ins_op0,
	input wire [7:0] ins_op1,
	input wire [7:0] ins_post,
	input wire [7:0] ins_mem_data,
	input wire ins_taken,
	// Completion
	output reg done_r,
	output reg illegal_r,
	output reg [4:0] cycles_r,
	// Stack memory port, read data valid in the same cycle
	output reg [15:0] mem_addr,
	output reg [7:0] mem_wdata,
	output reg mem_we,
	output reg mem_re,
	input wire [7:0] mem_rdata,
	// Programming model
	output reg [7:0] acc_a_r,
	output reg [7:0] acc_b_r,
	output reg [15:0] idx_x_r,
	output reg [15:0] idx_y_r,
	output reg [15:0] usp_r,
	output reg [15:0] ssp_r,
	output reg [15:0] pc_r,
	output reg [7:0] direct_page_base_r,
	output reg [7:0] flag_register_r
);
	localparam ST_IDLE = 2'd0;
	localparam ST_STACK = 2'd1;
	localparam ST_VEC = 2'd2;
	localparam ST_WAIT = 2'd3;

	reg [1:0] state_r;
	reg [4:0] cnt_r;
	reg [7:0] mask_r;
	reg half_r;
	reg push_r;
	reg use_u_r;
	reg is_rti_r;
	reg vec_lo_r;
	reg [15:0] vec_r;
	reg [7:0] post_r;
	wire [3:0] idx_cyc;
	wire [1:0] idx_byt;

	c8x_idx_cost u_cost (
		.post(ins_post),
		.extra_cyc(idx_cyc),
		.extra_byt(idx_byt)
	);

	assign ins_ready = (state_r == ST_IDLE);

	// ==========================================================
	// Register code helpers
	function is16;
		input [3:0] c;
		begin
			is16 = !c[3] && (c <= `C8X_R_PC);
		end
	endfunction

	function valid_code;
		input [3:0] c;
		begin
			valid_code = is16(c) || (c[3] && (c <= `C8X_R_DP));
		end
	endfunction

	function [3:0] count_ones;
		input [7:0] m;
		integer i;
		begin
			count_ones = 4'h0;
			for (i = 0; i < 8; i = i + 1) begin
				if (m[i])
					count_ones = count_ones + (i >= 4 ? 4'h2 : 4'h1);
			end
		end
	endfunction

	// ==========================================================
	// Read side of the programming model
	reg [15:0] rd_src;
	reg [15:0] rd_dst;
	always @* begin
		rd_src = 16'h0000;
		rd_dst = 16'h0000;
		case (ins_post[7:4])
		`C8X_R_D: rd_src = {acc_a_r, acc_b_r};
		`C8X_R_X: rd_src = idx_x_r;
		`C8X_R_Y: rd_src = idx_y_r;
		`C8X_R_U: rd_src = usp_r;
		`C8X_R_S: rd_src = ssp_r;
		`C8X_R_PC: rd_src = pc_r;
		`C8X_R_A: rd_src = {8'hff, acc_a_r};
		`C8X_R_B: rd_src = {8'hff, acc_b_r};
		`C8X_R_CC: rd_src = {8'hff, flag_register_r};
		`C8X_R_DP: rd_src = {8'hff, direct_page_base_r};
		default: rd_src = 16'hffff;
		endcase
		case (ins_post[3:0])
		`C8X_R_D: rd_dst = {acc_a_r, acc_b_r};
		`C8X_R_X: rd_dst = idx_x_r;
		`C8X_R_Y: rd_dst = idx_y_r;
		`C8X_R_U: rd_dst = usp_r;
		`C8X_R_S: rd_dst = ssp_r;
		`C8X_R_PC: rd_dst = pc_r;
		`C8X_R_A: rd_dst = {8'hff, acc_a_r};
		`C8X_R_B: rd_dst = {8'hff, acc_b_r};
		`C8X_R_CC: rd_dst = {8'hff, flag_register_r};
		`C8X_R_DP: rd_dst = {8'hff, direct_page_base_r};
		default: rd_dst = 16'hffff;
		endcase
	end

	// ==========================================================
	// Stack step: next register bit and the byte it moves
	reg [2:0] sbit;
	reg [15:0] sval;
	reg [15:0] sp_cur;
	reg [7:0] sbyte;
	reg wide;
	integer k;
	always @* begin
		sbit = 3'd0;
		for (k = 0; k < 8; k = k + 1) begin
			if (push_r ? (mask_r[k] && sbit == 3'd0) || mask_r[k]
			    : mask_r[7 - k])
				sbit = push_r ? k[2:0] : 3'd7 - k[2:0];
		end
		sp_cur = use_u_r ? usp_r : ssp_r;
		wide = sbit[2];
		case (sbit)
		3'd0: sval = {8'h00, flag_register_r};
		3'd1: sval = {8'h00, acc_a_r};
		3'd2: sval = {8'h00, acc_b_r};
		3'd3: sval = {8'h00, direct_page_base_r};
		3'd4: sval = idx_x_r;
		3'd5: sval = idx_y_r;
		3'd6: sval = use_u_r ? ssp_r : usp_r;
		default: sval = pc_r;
		endcase
		// Wide pushes go low byte first; half_r marks the second byte.
		sbyte = (wide && !half_r) ? sval[7:0] : (wide ? sval[15:8] :
		    sval[7:0]);
		mem_addr = 16'h0000;
		mem_wdata = 8'h00;
		mem_we = 1'b0;
		mem_re = 1'b0;
		if (state_r == ST_STACK) begin
			mem_addr = push_r ? sp_cur - 16'h0001 : sp_cur;
			mem_wdata = sbyte;
			mem_we = push_r;
			mem_re = !push_r;
		end else if (state_r == ST_VEC) begin
			mem_addr = vec_lo_r ? vec_r + 16'h0001 : vec_r;
			mem_re = 1'b1;
		end
	end

	// ==========================================================
	// Decode of the issued instruction
	// [RULE15] page prefixes
	wire pg2 = (ins_op0 == `C8X_PAGE2);
	wire pg3 = (ins_op0 == `C8X_PAGE3);
	wire [7:0] opc = (pg2 || pg3) ? ins_op1 : ins_op0;
	wire [7:0] sbc_src = (opc == `C8X_OP_SBC_A) ? acc_a_r : acc_b_r;
	wire [8:0] sbc_res = {1'b0, sbc_src} - {1'b0, ins_post} -
	    {8'h00, flag_register_r[`C8X_CC_C]};
	wire [15:0] prod = acc_a_r * acc_b_r;
	wire [7:0] tst_v = (opc == `C8X_OP_TST_A) ? acc_a_r :
	    (opc == `C8X_OP_TST_B) ? acc_b_r : ins_mem_data;
	wire [7:0] shr_v = ((opc == `C8X_OP_SHR_A) ? acc_a_r : acc_b_r) >> 1;

	// ==========================================================
	// Sequencer and programming model
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			cnt_r <= 5'h00;
			cycles_r <= 5'h00;
			mask_r <= 8'h00;
			half_r <= 1'b0;
			push_r <= 1'b0;
			use_u_r <= 1'b0;
			is_rti_r <= 1'b0;
			vec_lo_r <= 1'b0;
			vec_r <= 16'h0000;
			post_r <= 8'h00;
			done_r <= 1'b0;
			illegal_r <= 1'b0;
			acc_a_r <= 8'h00;
			acc_b_r <= 8'h00;
			idx_x_r <= 16'h0000;
			idx_y_r <= 16'h0000;
			usp_r <= 16'h0000;
			ssp_r <= 16'h0000;
			pc_r <= 16'h0000;
			direct_page_base_r <= 8'h00;
			flag_register_r <= `C8X_CC_RESET;
		end else begin
			done_r <= 1'b0;
			cnt_r <= cnt_r + 5'h01;
			case (state_r)
			ST_IDLE: begin
				cnt_r <= 5'h01;
				if (ins_valid) begin
					illegal_r <= 1'b0;
					state_r <= ST_WAIT;
					half_r <= 1'b0;
					is_rti_r <= 1'b0;
					post_r <= ins_post;
					cycles_r <= `C8X_CYC_ILL;
					if (pg2 && opc[7:4] == 4'h2) begin
						// [RULE11] five or six cycles
						cycles_r <= `C8X_CYC_LBR + {4'h0,
						    ins_taken && opc != `C8X_OP_LBRN};
					end else if (opc == `C8X_OP_TRAP) begin
						// [RULE16] stack whole set
						mask_r <= `C8X_MASK_ALL;
						// Traps carry no postbyte; mark the full set instead.
						post_r <= `C8X_MASK_ALL;
						push_r <= 1'b1;
						use_u_r <= 1'b0;
						state_r <= ST_STACK;
						flag_register_r[`C8X_CC_E] <= 1'b1;
						vec_r <= pg2 ? `C8X_VEC_TRAP2 : pg3 ?
						    `C8X_VEC_TRAP3 : `C8X_VEC_TRAP1;
						cycles_r <= (pg2 || pg3) ?
						    `C8X_CYC_TRAP23 : `C8X_CYC_TRAP1;
					end else if (pg2 || pg3) begin
						illegal_r <= 1'b1;
					end else begin
						case (opc)
						`C8X_OP_PSH_SYS, `C8X_OP_PSH_USR,
						`C8X_OP_PUL_SYS, `C8X_OP_PUL_USR: begin
							// [RULE1] [RULE2] own stack
							mask_r <= ins_post;
							push_r <= !opc[0];
							use_u_r <= opc[1];
							state_r <= ST_STACK;
							// [RULE3] base plus bytes
							cycles_r <= `C8X_CYC_STACK +
							    {1'b0, count_ones(ins_post)};
						end
						`C8X_OP_RTI: begin
							mask_r <= `C8X_MASK_CC;
							push_r <= 1'b0;
							use_u_r <= 1'b0;
							is_rti_r <= 1'b1;
							state_r <= ST_STACK;
							cycles_r <= `C8X_CYC_RTI_S;
						end
						`C8X_OP_MUL: begin
							// [RULE5] unsigned product
							acc_a_r <= prod[15:8];
							acc_b_r <= prod[7:0];
							flag_register_r[`C8X_CC_Z] <= prod == 16'h0;
							flag_register_r[`C8X_CC_C] <= prod[7];
							cycles_r <= `C8X_CYC_MUL;
						end
						`C8X_OP_SEXT: begin
							// [RULE6] replicate sign bit
							acc_a_r <= {8{acc_b_r[7]}};
							flag_register_r[`C8X_CC_N] <= acc_b_r[7];
							flag_register_r[`C8X_CC_Z] <= acc_b_r == 8'h0;
							flag_register_r[`C8X_CC_V] <= 1'b0;
							cycles_r <= `C8X_CYC_SEXT;
						end
						`C8X_OP_XFER, `C8X_OP_EXCH: begin
							cycles_r <= opc[0] ? `C8X_CYC_XFER :
							    `C8X_CYC_EXCH;
							// [RULE7] [RULE8] [RULE9] width match
							if (!valid_code(ins_post[7:4]) ||
							    !valid_code(ins_post[3:0]) ||
							    is16(ins_post[7:4]) !=
							    is16(ins_post[3:0])) begin
								illegal_r <= 1'b1;
							end else begin
								wr_reg(ins_post[3:0], rd_src);
								if (!opc[0])
									wr_reg(ins_post[7:4], rd_dst);
							end
						end
						`C8X_OP_TST_A, `C8X_OP_TST_B, `C8X_OP_TST_DIR,
						`C8X_OP_TST_IDX, `C8X_OP_TST_EXT: begin
							// [RULE10] flags only
							flag_register_r[`C8X_CC_N] <= tst_v[7];
							flag_register_r[`C8X_CC_Z] <= tst_v == 8'h0;
							flag_register_r[`C8X_CC_V] <= 1'b0;
							cycles_r <= (opc == `C8X_OP_TST_DIR) ?
							    `C8X_CYC_TST_DIR :
							    (opc == `C8X_OP_TST_EXT) ?
							    `C8X_CYC_TST_EXT :
							    (opc == `C8X_OP_TST_IDX) ?
							    // [RULE12] indexed extra
							    `C8X_CYC_TST_IDX + {1'b0, idx_cyc} :
							    `C8X_CYC_INH;
						end
						`C8X_OP_FLAGS_OR_IMMEDIATE: begin
							// [RULE14] direct flag set
							flag_register_r <= flag_register_r | ins_post;
							cycles_r <= `C8X_CYC_FLAGS_OR_IMMEDIATE;
						end
						`C8X_OP_SHR_A, `C8X_OP_SHR_B: begin
							// [RULE17] zero in, bit0 out
							if (opc == `C8X_OP_SHR_A)
								acc_a_r <= shr_v;
							else
								acc_b_r <= shr_v;
							flag_register_r[`C8X_CC_C] <= opc[4] ?
							    acc_b_r[0] : acc_a_r[0];
							flag_register_r[`C8X_CC_N] <= 1'b0;
							flag_register_r[`C8X_CC_Z] <= shr_v == 8'h0;
							cycles_r <= `C8X_CYC_INH;
						end
						`C8X_OP_SBC_A, `C8X_OP_SBC_B: begin
							// [RULE13] half-carry left as is
							if (opc == `C8X_OP_SBC_A)
								acc_a_r <= sbc_res[7:0];
							else
								acc_b_r <= sbc_res[7:0];
							flag_register_r[`C8X_CC_N] <= sbc_res[7];
							flag_register_r[`C8X_CC_Z] <=
							    sbc_res[7:0] == 8'h0;
							flag_register_r[`C8X_CC_V] <=
							    (sbc_src[7] ^ ins_post[7]) &
							    (sbc_src[7] ^ sbc_res[7]);
							flag_register_r[`C8X_CC_C] <= sbc_res[8];
							cycles_r <= `C8X_CYC_INH;
						end
						default: illegal_r <= 1'b1;
						endcase
					end
				end
			end
			ST_STACK: begin
				if (push_r) begin
					if (use_u_r)
						usp_r <= usp_r - 16'h0001;
					else
						ssp_r <= ssp_r - 16'h0001;
				end else begin
					if (use_u_r)
						usp_r <= usp_r + 16'h0001;
					else
						ssp_r <= ssp_r + 16'h0001;
					pull_byte(sbit, half_r, mem_rdata);
				end
				if (wide && !half_r) begin
					half_r <= 1'b1;
				end else begin
					half_r <= 1'b0;
					mask_r[sbit] <= 1'b0;
					if (mask_r == (8'h01 << sbit)) begin
						// [RULE14] restored flags decide length
						if (is_rti_r && sbit == 3'd0) begin
							mask_r <= mem_rdata[`C8X_CC_E] ?
							    8'hfe : `C8X_MASK_PC;
							cycles_r <= mem_rdata[`C8X_CC_E] ?
							    `C8X_CYC_RTI_L : `C8X_CYC_RTI_S;
						end else if (push_r && mask_r == 8'h01 &&
						    post_r == `C8X_MASK_ALL && !use_u_r &&
						    vec_r != 16'h0000) begin
							state_r <= ST_VEC;
							vec_lo_r <= 1'b0;
							// [RULE4] only first trap masks
							if (vec_r == `C8X_VEC_TRAP1) begin
								flag_register_r[`C8X_CC_I] <= 1'b1;
								flag_register_r[`C8X_CC_F] <= 1'b1;
							end
						end else begin
							state_r <= ST_WAIT;
						end
					end
				end
			end
			ST_VEC: begin
				vec_lo_r <= 1'b1;
				if (vec_lo_r) begin
					pc_r[7:0] <= mem_rdata;
					vec_r <= 16'h0000;
					state_r <= ST_WAIT;
				end else begin
					pc_r[15:8] <= mem_rdata;
				end
			end
			default: begin
				if (cnt_r >= cycles_r) begin
					done_r <= 1'b1;
					vec_r <= 16'h0000;
					state_r <= ST_IDLE;
				end
			end
			endcase
		end
	end

	// ==========================================================
	// Write helpers for the programming model
	task wr_reg;
		input [3:0] c;
		input [15:0] v;
		begin
			case (c)
			`C8X_R_D: begin
				acc_a_r <= v[15:8];
				acc_b_r <= v[7:0];
			end
			`C8X_R_X: idx_x_r <= v;
			`C8X_R_Y: idx_y_r <= v;
			`C8X_R_U: usp_r <= v;
			`C8X_R_S: ssp_r <= v;
			`C8X_R_PC: pc_r <= v;
			`C8X_R_A: acc_a_r <= v[7:0];
			`C8X_R_B: acc_b_r <= v[7:0];
			`C8X_R_CC: flag_register_r <= v[7:0];
			`C8X_R_DP: direct_page_base_r <= v[7:0];
			default: acc_a_r <= acc_a_r;
			endcase
		end
	endtask

	// Pulls come high byte first for wide registers.
	task pull_byte;
		input [2:0] b;
		input lo;
		input [7:0] d;
		begin
			case (b)
			3'd0: flag_register_r <= d;
			3'd1: acc_a_r <= d;
			3'd2: acc_b_r <= d;
			3'd3: direct_page_base_r <= d;
			3'd4: if (lo) idx_x_r[7:0] <= d; else idx_x_r[15:8] <= d;
			3'd5: if (lo) idx_y_r[7:0] <= d; else idx_y_r[15:8] <= d;
			3'd6: begin
				if (use_u_r) begin
					if (lo) ssp_r[7:0] <= d; else ssp_r[15:8] <= d;
				end else begin
					if (lo) usp_r[7:0] <= d; else usp_r[15:8] <= d;
				end
			end
			default: if (lo) pc_r[7:0] <= d; else pc_r[15:8] <= d;
			endcase
		end
	endtask
endmodule // c8x_exec

// ==== sim/c8x_exec_asserts.sv ====
// Checker for the execute slice, bound to its ports.
`timescale 1ns/1ps
`include "c8x_defines.vh"
module c8x_exec_chk (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// Issue and completion
	input wire ins_valid,
	input wire ins_ready,
	input wire [7:0] ins_op0,
	input wire [7:0] ins_op1,
	input wire [7:0] ins_post,
	input wire ins_taken,
	input wire done_r,
	input wire illegal_r,
	input wire [4:0] cycles_r,
	// Stack port and programming model
	input wire [15:0] mem_addr,
	input wire [7:0] mem_wdata,
	input wire mem_we,
	input wire [7:0] acc_a_r,
	input wire [7:0] acc_b_r,
	input wire [15:0] ssp_r,
	input wire [7:0] flag_register_r
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ==========================================================
	// Issue capture
	wire acpt = ins_valid && ins_ready;
	reg [7:0] op0_r;
	reg [7:0] op1_r;
	reg [7:0] post_r;
	reg [7:0] cc_r;
	reg tkn_r;
	wire stk_op = (op0_r[7:2] == 6'h0d);
	wire [4:0] stk_byt;
	assign stk_byt = 5'h00 + post_r[0] + post_r[1] + post_r[2] + post_r[3]
		+ {post_r[4], 1'b0} + {post_r[5], 1'b0} + {post_r[6], 1'b0}
		+ {post_r[7], 1'b0};
	wire pfx = (op0_r == `C8X_PAGE2) || (op0_r == `C8X_PAGE3);
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			op0_r <= 8'h00;
			op1_r <= 8'h00;
			post_r <= 8'h00;
			cc_r <= 8'h00;
			tkn_r <= 1'b0;
		end else if (acpt) begin
			op0_r <= ins_op0;
			op1_r <= ins_op1;
			post_r <= ins_post;
			cc_r <= flag_register_r;
			tkn_r <= ins_taken;
		end
	end
	// ==========================================================
	// Properties
	a_mul_product: assert property (acpt && ins_op0 == `C8X_OP_MUL |=>
		{acc_a_r, acc_b_r} == 16'($past(acc_a_r)) * 16'($past(acc_b_r)))
		else $error("multiply product wrong");
	a_mul_carry: assert property (acpt && ins_op0 == `C8X_OP_MUL |=>
		flag_register_r[0] == acc_b_r[7]) else $error("multiply carry wrong");
	a_mul_cycles: assert property (done_r && op0_r == `C8X_OP_MUL |->
		cycles_r == 5'h0b) else $error("multiply cycle count wrong");
	a_sext_fill: assert property (acpt && ins_op0 == `C8X_OP_SEXT |=>
		acc_a_r == {8{acc_b_r[7]}} && flag_register_r[3] == acc_b_r[7]
		&& !flag_register_r[1]) else $error("sign extend wrong");
	a_test_keeps: assert property (acpt && ins_op0 == `C8X_OP_TST_A |=>
		$stable(acc_a_r) && flag_register_r[3] == acc_a_r[7]
		&& flag_register_r[2] == (acc_a_r == 8'h00) && !flag_register_r[1])
		else $error("test flags wrong");
	a_push_write: assert property (acpt && ins_op0 == `C8X_OP_PSH_SYS
		&& ins_post == 8'h04 |=> mem_we && mem_addr == $past(ssp_r) - 16'h0001
		&& mem_wdata == $past(acc_b_r)) else $error("push write wrong");
	a_stack_cycles: assert property (done_r && stk_op |->
		cycles_r == 5'h05 + stk_byt) else $error("stack cycle count wrong");
	a_trap_masks: assert property (done_r && op0_r == `C8X_OP_TRAP |->
		flag_register_r[6] && flag_register_r[4])
		else $error("first trap masks not set");
	a_trap_keep: assert property (done_r && pfx && op1_r == `C8X_OP_TRAP
		|-> flag_register_r[6] == cc_r[6] && flag_register_r[4] == cc_r[4])
		else $error("later trap changed masks");
	a_branch_cycles: assert property (done_r && op0_r == `C8X_PAGE2
		&& op1_r[7:4] == 4'h2 && op1_r != `C8X_OP_LBRN
		|-> cycles_r == 5'h05 + {4'h0, tkn_r}) else $error("branch cycles wrong");
	a_xfer_width: assert property (done_r && op0_r == `C8X_OP_XFER
		&& post_r[7] != post_r[3] |-> illegal_r) else $error("mixed pair taken");
	a_done_bound: assert property (acpt |-> ##[1:30] done_r)
		else $error("instruction never finished");
	a_ready_done: assert property (done_r |-> ins_ready)
		else $error("not ready at completion");
endmodule // c8x_exec_chk

bind c8x_exec c8x_exec_chk i_chk (.ref_clk(ref_clk), .rst(rst),
	.ins_valid(ins_valid), .ins_ready(ins_ready), .ins_op0(ins_op0),
	.ins_op1(ins_op1), .ins_post(ins_post), .ins_taken(ins_taken),
	.done_r(done_r), .illegal_r(illegal_r), .cycles_r(cycles_r),
	.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
	.acc_a_r(acc_a_r), .acc_b_r(acc_b_r), .ssp_r(ssp_r),
	.flag_register_r(flag_register_r));

// ==== sim/test_c8x_exec.sv ====
// Self-checking testbench for the execute slice.
`timescale 1ns/1ps
`include "c8x_defines.vh"
module test_c8x_exec;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic ins_valid = 1'b0;
	logic [7:0] ins_op0 = 8'h00;
	logic [7:0] ins_op1 = 8'h00;
	logic [7:0] ins_post = 8'h00;
	logic [7:0] ins_mem_data = 8'h00;
	logic ins_taken = 1'b0;
	wire ins_ready, done_r, illegal_r, mem_we, mem_re;
	wire [4:0] cycles_r;
	wire [15:0] mem_addr, idx_x_r, idx_y_r, usp_r, ssp_r, pc_r;
	wire [7:0] mem_wdata, mem_rdata, acc_a_r, acc_b_r, dpb, cc;
	logic [7:0] mem [0:65535];
	int errors = 0;
	int cmp_count = 0;
	int cyc_cnt = 0;
	c8x_exec i_dut (.ref_clk(ref_clk), .rst(rst), .ins_valid(ins_valid),
		.ins_ready(ins_ready), .ins_op0(ins_op0), .ins_op1(ins_op1),
		.ins_post(ins_post), .ins_mem_data(ins_mem_data),
		.ins_taken(ins_taken), .done_r(done_r), .illegal_r(illegal_r),
		.cycles_r(cycles_r), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata),
		.acc_a_r(acc_a_r), .acc_b_r(acc_b_r), .idx_x_r(idx_x_r),
		.idx_y_r(idx_y_r), .usp_r(usp_r), .ssp_r(ssp_r), .pc_r(pc_r),
		.direct_page_base_r(dpb), .flag_register_r(cc));
	always #25 ref_clk = ~ref_clk;
	// Stack memory answers only while read is strobed.
	assign mem_rdata = mem_re ? mem[mem_addr] : 8'h5a;
	always @(posedge ref_clk) begin
		if (mem_we)
			mem[mem_addr] <= mem_wdata;
	end
	// ==========================================================
	// Tasks
	task chk(input string what, input [31:0] seen, input [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Issues one instruction, waits for completion, checks cycles.
	task run(input [7:0] o0, o1, post, md, input tk, input [4:0] cyc);
		int n;
		@(posedge ref_clk);
		ins_op0 <= o0;
		ins_op1 <= o1;
		ins_post <= post;
		ins_mem_data <= md;
		ins_taken <= tk;
		ins_valid <= 1'b1;
		@(posedge ref_clk);
		ins_valid <= 1'b0;
		#1;
		for (n = 0; n < 40 && done_r !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		chk("done", done_r, 1'b1);
		if (cyc != 5'h00)
			chk("cycles", cycles_r, cyc);
	endtask
	always @(posedge ref_clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 3000) begin
			errors++;
			print_verdict;
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'h00;
		mem[16'h0000] = 8'hc8;
		mem[16'h0001] = 8'h0f;
		mem[16'hfffa] = 8'h12;
		mem[16'hfffb] = 8'h34;
		mem[16'hfff4] = 8'h22;
		mem[16'hfff2] = 8'h33;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		#1;
		chk("reset flags", cc, 8'h50);
		run(`C8X_OP_PUL_SYS, 8'h00, 8'h06, 8'h00, 1'b0, 5'h07);
		chk("pull ab", {acc_a_r, acc_b_r}, 16'hc80f);
		chk("pull sp", ssp_r, 16'h0002);
		run(`C8X_OP_MUL, 8'h00, 8'h00, 8'h00, 1'b0, 5'h0b);
		chk("product", {acc_a_r, acc_b_r}, 16'h0bb8);
		chk("mul carry", cc[0], 1'b1);
		run(`C8X_OP_SEXT, 8'h00, 8'h00, 8'h00, 1'b0, 5'h02);
		chk("sext", {acc_a_r, cc[3], cc[1]}, 10'h3fe);
		$display("test arithmetic done");
		run(`C8X_OP_TST_A, 8'h00, 8'h00, 8'h00, 1'b0, 5'h02);
		chk("test a", {acc_a_r, cc[3:1]}, 11'h7fc);
		run(`C8X_OP_TST_DIR, 8'h00, 8'h00, 8'h00, 1'b0, 5'h06);
		chk("test zero", cc[3:1], 3'h2);
		run(`C8X_OP_TST_IDX, 8'h00, 8'h89, 8'h80, 1'b0, 5'h0a);
		chk("test neg", cc[3:1], 3'h4);
		run(`C8X_OP_TST_EXT, 8'h00, 8'h00, 8'h01, 1'b0, 5'h07);
		run(`C8X_OP_SHR_A, 8'h00, 8'h00, 8'h00, 1'b0, 5'h02);
		chk("shift", {acc_a_r, cc[3], cc[2], cc[0]}, 11'h3f9);
		$display("test flags done");
		run(`C8X_OP_PSH_SYS, 8'h00, 8'h04, 8'h00, 1'b0, 5'h06);
		chk("push s", {mem[16'h0001], ssp_r}, 24'hb80001);
		run(`C8X_OP_PSH_USR, 8'h00, 8'h04, 8'h00, 1'b0, 5'h06);
		chk("push u", {mem[16'hffff], usp_r}, 24'hb8ffff);
		run(`C8X_OP_PUL_USR, 8'h00, 8'h04, 8'h00, 1'b0, 5'h06);
		chk("pull u", {acc_b_r, usp_r}, 24'hb80000);
		$display("test stacks done");
		run(`C8X_OP_XFER, 8'h00, 8'h8b, 8'h00, 1'b0, 5'h06);
		chk("dp", dpb, 8'h7f);
		run(`C8X_OP_XFER, 8'h00, 8'h81, 8'h00, 1'b0, 5'h00);
		chk("mixed", {illegal_r, idx_x_r}, 17'h10000);
		run(`C8X_OP_XFER, 8'h00, 8'h01, 8'h00, 1'b0, 5'h06);
		chk("x", {illegal_r, idx_x_r}, 17'h07fb8);
		run(`C8X_OP_XFER, 8'h00, 8'h04, 8'h00, 1'b0, 5'h06);
		chk("s", ssp_r, 16'h7fb8);
		$display("test transfer done");
		run(`C8X_OP_PUL_SYS, 8'h00, 8'h01, 8'h00, 1'b0, 5'h06);
		chk("cc pull", cc, 8'h00);
		run(`C8X_PAGE2, `C8X_OP_TRAP, 8'h00, 8'h00, 1'b0, 5'h14);
		chk("trap2 masks", cc & 8'h50, 8'h00);
		chk("trap2", {pc_r, ssp_r}, 32'h22007fad);
		run(`C8X_OP_TRAP, 8'h00, 8'h00, 8'h00, 1'b0, 5'h13);
		chk("trap1 masks", cc & 8'h50, 8'h50);
		chk("trap1", {pc_r, ssp_r}, 32'h12347fa1);
		run(`C8X_OP_RTI, 8'h00, 8'h00, 8'h00, 1'b0, 5'h0f);
		chk("return", {pc_r, ssp_r}, 32'h22007fad);
		chk("return cc", cc & 8'hd0, 8'h80);
		run(`C8X_PAGE3, `C8X_OP_TRAP, 8'h00, 8'h00, 1'b0, 5'h14);
		chk("trap3", pc_r, 16'h3300);
		run(`C8X_OP_FLAGS_OR_IMMEDIATE, 8'h00, 8'h25, 8'h00, 1'b0, 5'h03);
		chk("or flags", cc & 8'h05, 8'h05);
		run(`C8X_OP_SBC_A, 8'h00, 8'h10, 8'h00, 1'b0, 5'h02);
		chk("sbc", {acc_a_r, cc}, 16'h6ea0);
		run(`C8X_OP_EXCH, 8'h00, 8'h89, 8'h00, 1'b0, 5'h08);
		chk("exchange", {acc_a_r, acc_b_r}, 16'hb86e);
		$display("test traps done");
		run(`C8X_PAGE2, 8'h26, 8'h00, 8'h00, 1'b0, 5'h05);
		run(`C8X_PAGE2, 8'h26, 8'h00, 8'h00, 1'b1, 5'h06);
		chk("branch pc", pc_r, 16'h3300);
		$display("test branches done");
		print_verdict;
	end
endmodule // test_c8x_exec
